/* File: design/ctu_pkg.sv */
// Package: register map, field positions and reset values of the charge time unit control
package ctu_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] OFS_CTRL_HIGH = 4'h0;
    localparam logic [3:0] OFS_CTRL_LOW  = 4'h1;
    localparam logic [3:0] OFS_IRQ_STAT  = 4'h2;
    localparam logic [3:0] OFS_IRQ_EN    = 4'h3;
    localparam logic [3:0] OFS_IRQ_CLR   = 4'h4;
    localparam logic [3:0] OFS_UNIT_STAT = 4'h5;

    // High control fields
    localparam int BIT_UNIT_EN   = 7;
    localparam int BIT_IDLE_STOP = 5;
    localparam int BIT_DELAY_GEN = 4;
    localparam int BIT_EDGE_GATE = 3;
    localparam int BIT_EDGE_ORD  = 2;
    localparam int BIT_SRC_GND   = 1;
    localparam int BIT_TRIG_EN   = 0;
    localparam logic [7:0] CTRL_HIGH_WMASK = 8'hbf;

    // Low control fields
    localparam int BIT_POL2  = 7;
    localparam int SEL2_LSB  = 5;
    localparam int BIT_POL1  = 4;
    localparam int SEL1_LSB  = 2;
    localparam int BIT_STAT2 = 1;
    localparam int BIT_STAT1 = 0;

    // Interrupt status fields
    localparam int BIT_IRQ_DONE = 0;
    localparam logic [7:0] IRQ_MASK = 8'h01;

    // Reset values
    localparam logic [7:0] RST_CTRL_HIGH = 8'h00;
    localparam logic [7:0] RST_CTRL_LOW  = 8'h00;
    localparam logic [7:0] RST_IRQ       = 8'h00;

    // Source select encodings
    localparam logic [1:0] SEL_PIN_ONE  = 2'h3;
    localparam logic [1:0] SEL_PIN_TWO  = 2'h2;
    localparam logic [1:0] SEL_TRIG_ONE = 2'h1;
    localparam logic [1:0] SEL_TRIG_TWO = 2'h0;
endpackage

/* File: design/ctu_edge_ctrl.sv */
// Control logic of the charge time unit: control registers, edge status, source and trigger gating
`timescale 1ns/100ps
// What this block does
// - Enable bit 7 turns the unit on
// - Bit 6 reads zero, writes ignored
// - Idle-stop bit blocks edges and delay generation during Idle
// - Bit 4 enables edge delay generation
// - Edge gating bit 3 passes or blocks edges
// - Ordering bit: second edge needs first edge
// - Bit 1 grounds the current source output
// - Trigger output only while bit 0 set
// - Each channel picks one of four sources
// - Special event output starts a conversion
// - Edges set status; software sets or clears
// - Current on only when one status set
// - Source on-to-off sets flag; enable gates interrupt
// - Select 11,10,01,00; polarity 1 positive
module ctu_edge_ctrl
(
    input  wire logic                 MCLK,
    input  wire logic                 SYS_RST,
    input  wire logic [3:0]           REG_ADDR,
    input  wire logic [7:0]           REG_WDATA,
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    output logic      [7:0]           REG_RDATA,
    input  wire logic                 EDGE_PIN_ONE,
    input  wire logic                 EDGE_PIN_TWO,
    input  wire logic                 TIMER_TRIG_ONE,
    input  wire logic                 TIMER_TRIG_TWO,
    input  wire logic                 IDLE_MODE,
    output logic                      CURRENT_SOURCE_ON,
    output logic                      SOURCE_GROUND,
    output logic                      DELAY_GEN_ON,
    output logic                      CONVERTER_TRIGGER,
    output logic                      IRQ
);
    import ctu_pkg::*;

    logic [7:0] ctrl_high_ff;
    logic [7:0] ctrl_low_ff;
    logic [7:0] irq_stat_ff;
    logic [7:0] irq_en_ff;
    logic [2:0] pin1_sync_ff;
    logic [2:0] pin2_sync_ff;
    logic       pin1_lvl_ff;
    logic       pin2_lvl_ff;
    logic       pin1_agree;
    logic       pin2_agree;
    logic       src_on_ff;
    logic       stat1_d;
    logic       stat2_d;
    logic       active;
    logic       edges_open;
    logic [1:0] sel1;
    logic [1:0] sel2;
    logic       pol1;
    logic       pol2;
    logic       level1;
    logic       level2;
    logic       order_ok;
    logic       edge1_hit;
    logic       edge2_hit;
    logic       nxt_src_on;
    logic       src_off_event;
    logic       nxt_irq;
    logic [7:0] nxt_rdata;
    logic       wr_high;
    logic       wr_low;
    logic       wr_irq_en;
    logic       wr_irq_clr;

    // Pick one of four level sources for a channel
    function automatic logic pick_source(input logic [1:0] sel, input logic p1, input logic p2,
                                         input logic t1, input logic t2);
        logic r;
        r = 1'b0;
        unique case (sel)
            SEL_PIN_ONE:  r = p1;
            SEL_PIN_TWO:  r = p2;
            SEL_TRIG_ONE: r = t1;
            SEL_TRIG_TWO: r = t2;
        endcase
        return r;
    endfunction

    // Write strobe aimed at one offset; shared by every writable register
    function automatic logic addr_write(input logic wr, input logic [3:0] a, input logic [3:0] ofs);
        return wr & (a == ofs);
    endfunction

    // Pin one is asynchronous: three stages before its level is trusted
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pin1_sync_ff <= 3'h0;
        end
        else
        begin
            pin1_sync_ff <= {pin1_sync_ff[1:0], EDGE_PIN_ONE};
        end
    end

    // Pin two passes the same three stages
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pin2_sync_ff <= 3'h0;
        end
        else
        begin
            pin2_sync_ff <= {pin2_sync_ff[1:0], EDGE_PIN_TWO};
        end
    end

    // A level counts only once stages two and three agree
    assign pin1_agree = (pin1_sync_ff[1] == pin1_sync_ff[2]);
    assign pin2_agree = (pin2_sync_ff[1] == pin2_sync_ff[2]);

    // Filtered pin one; a one-cycle glitch never reaches it
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pin1_lvl_ff <= 1'b0;
        end
        else if (pin1_agree)
        begin
            pin1_lvl_ff <= pin1_sync_ff[2];
        end
    end

    // Filtered pin two
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pin2_lvl_ff <= 1'b0;
        end
        else if (pin2_agree)
        begin
            pin2_lvl_ff <= pin2_sync_ff[2];
        end
    end

    // Unit runs when enabled and not halted by Idle
    assign active = ctrl_high_ff[BIT_UNIT_EN]
                    & ~(ctrl_high_ff[BIT_IDLE_STOP] & IDLE_MODE);
    assign edges_open = active & ctrl_high_ff[BIT_EDGE_GATE];

    // Channel configuration fields of control low
    assign sel1 = ctrl_low_ff[SEL1_LSB+:2];
    assign sel2 = ctrl_low_ff[SEL2_LSB+:2];
    assign pol1 = ctrl_low_ff[BIT_POL1];
    assign pol2 = ctrl_low_ff[BIT_POL2];

    // Chosen source levels; timer triggers share this clock, so no sync
    assign level1 = pick_source(sel1, pin1_lvl_ff, pin2_lvl_ff, TIMER_TRIG_ONE, TIMER_TRIG_TWO);
    assign level2 = pick_source(sel2, pin1_lvl_ff, pin2_lvl_ff, TIMER_TRIG_ONE, TIMER_TRIG_TWO);

    // Ordering holds channel two back until channel one has fired
    assign order_ok = ~ctrl_high_ff[BIT_EDGE_ORD] | ctrl_low_ff[BIT_STAT1];

    // Level-sensitive: a matching level is a hit on every cycle it stands
    assign edge1_hit = edges_open & (level1 == pol1);
    assign edge2_hit = edges_open & (level2 == pol2) & order_ok;

    // Register write decodes
    assign wr_high    = addr_write(REG_WR, REG_ADDR, OFS_CTRL_HIGH);
    assign wr_low     = addr_write(REG_WR, REG_ADDR, OFS_CTRL_LOW);
    assign wr_irq_en  = addr_write(REG_WR, REG_ADDR, OFS_IRQ_EN);
    assign wr_irq_clr = addr_write(REG_WR, REG_ADDR, OFS_IRQ_CLR);

    // Control high register; bit 6 is never stored
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ctrl_high_ff <= RST_CTRL_HIGH;
        end
        else if (wr_high)
        begin
            ctrl_high_ff <= REG_WDATA & CTRL_HIGH_WMASK;
        end
    end

    // Status bits: hardware set wins over a software clear in the same cycle
    always_comb
    begin
        stat1_d = wr_low ? REG_WDATA[BIT_STAT1] : ctrl_low_ff[BIT_STAT1];
        stat2_d = wr_low ? REG_WDATA[BIT_STAT2] : ctrl_low_ff[BIT_STAT2];
        stat1_d = stat1_d | edge1_hit;
        stat2_d = stat2_d | edge2_hit;
    end

    // Control low register: selects, polarities and edge status
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            ctrl_low_ff <= RST_CTRL_LOW;
        else
        begin
            if (wr_low)
                ctrl_low_ff[7:2] <= REG_WDATA[7:2];
            ctrl_low_ff[BIT_STAT1] <= stat1_d;
            ctrl_low_ff[BIT_STAT2] <= stat2_d;
        end
    end

    // Current flows only between edges, i.e. exactly one status set
    assign nxt_src_on = ctrl_high_ff[BIT_UNIT_EN]
                        & (ctrl_low_ff[BIT_STAT1] ^ ctrl_low_ff[BIT_STAT2]);
    assign src_off_event = src_on_ff & ~nxt_src_on;

    // Source state; its fall is the special event
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            src_on_ff <= 1'b0;
        end
        else
        begin
            src_on_ff <= nxt_src_on;
        end
    end

    // Current source enable toward the analog side
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            CURRENT_SOURCE_ON <= 1'b0;
        end
        else
        begin
            CURRENT_SOURCE_ON <= nxt_src_on;
        end
    end

    // Discharge switch obeys its bit even when disabled, so a cap can be emptied first
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            SOURCE_GROUND <= 1'b0;
        end
        else
        begin
            SOURCE_GROUND <= ctrl_high_ff[BIT_SRC_GND];
        end
    end

    // Delay generation pauses with the unit, Idle stop included
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            DELAY_GEN_ON <= 1'b0;
        end
        else
        begin
            DELAY_GEN_ON <= active & ctrl_high_ff[BIT_DELAY_GEN];
        end
    end

    // Special event pulse on source shut-off starts a conversion
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            CONVERTER_TRIGGER <= 1'b0;
        end
        else
        begin
            CONVERTER_TRIGGER <= ctrl_high_ff[BIT_TRIG_EN] & ctrl_high_ff[BIT_UNIT_EN]
                                 & src_off_event;
        end
    end

    // Sticky interrupt status; set beats clear
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            irq_stat_ff <= RST_IRQ;
        else
        begin
            if (wr_irq_clr)
                irq_stat_ff <= irq_stat_ff & ~REG_WDATA & IRQ_MASK;
            if (src_off_event)
                irq_stat_ff[BIT_IRQ_DONE] <= 1'b1;
        end
    end

    // Interrupt enable register
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            irq_en_ff <= RST_IRQ;
        end
        else if (wr_irq_en)
        begin
            irq_en_ff <= REG_WDATA & IRQ_MASK;
        end
    end

    // Any enabled status bit raises the line
    assign nxt_irq = |(irq_stat_ff & irq_en_ff);

    // Registered level interrupt
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            IRQ <= 1'b0;
        end
        else
        begin
            IRQ <= nxt_irq;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        nxt_rdata = 8'h00;
        unique case (REG_ADDR)
            OFS_CTRL_HIGH: nxt_rdata = ctrl_high_ff;
            OFS_CTRL_LOW:  nxt_rdata = ctrl_low_ff;
            OFS_IRQ_STAT:  nxt_rdata = irq_stat_ff;
            OFS_IRQ_EN:    nxt_rdata = irq_en_ff;
            OFS_UNIT_STAT: nxt_rdata = {5'h00, active, src_on_ff, 1'b0};
            default:       nxt_rdata = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            REG_RDATA <= 8'h00;
        end
        else
        begin
            REG_RDATA <= REG_RD ? nxt_rdata : 8'h00;
        end
    end
endmodule

/* File: bench/ctu_edge_ctrl_asserts.sv */
// Checker: port-level properties of the charge time unit control
`timescale 1ns/100ps
module ctu_edge_ctrl_asserts
    import ctu_pkg::*;
(
    input wire logic       MCLK,
    input wire logic       SYS_RST,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic       EDGE_PIN_ONE,
    input wire logic       EDGE_PIN_TWO,
    input wire logic       TIMER_TRIG_ONE,
    input wire logic       TIMER_TRIG_TWO,
    input wire logic       IDLE_MODE,
    input wire logic       CURRENT_SOURCE_ON,
    input wire logic       SOURCE_GROUND,
    input wire logic       DELAY_GEN_ON,
    input wire logic       CONVERTER_TRIGGER,
    input wire logic       IRQ
);
    logic [7:0] ctrl_ff;
    logic       irq_en_ff;
    // Shadow of control high and interrupt enable, rebuilt from bus writes only
    always_ff @(posedge MCLK or posedge SYS_RST)
        if (SYS_RST)
        begin
            ctrl_ff   <= RST_CTRL_HIGH;
            irq_en_ff <= 1'b0;
        end
        else if (REG_WR)
        begin
            if (REG_ADDR == OFS_CTRL_HIGH)
                ctrl_ff <= REG_WDATA & CTRL_HIGH_WMASK;
            if (REG_ADDR == OFS_IRQ_EN)
                irq_en_ff <= REG_WDATA[BIT_IRQ_DONE];
        end
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    a_bit6_reads_zero: assert property (REG_RD && REG_ADDR == OFS_CTRL_HIGH |=> REG_RDATA[6] == 1'b0)
        else $error("bit 6 read back set");
    a_ground_follows_bit: assert property (SOURCE_GROUND == $past(ctrl_ff[BIT_SRC_GND]))
        else $error("ground output differs from its bit");
    a_delay_needs_bits: assert property (DELAY_GEN_ON |-> $past(ctrl_ff[BIT_DELAY_GEN]) && $past(ctrl_ff[BIT_UNIT_EN]))
        else $error("delay output without enable");
    a_trig_needs_bits: assert property (CONVERTER_TRIGGER |-> $past(ctrl_ff[BIT_TRIG_EN]) && $past(ctrl_ff[BIT_UNIT_EN]))
        else $error("trigger while disabled");
    a_trig_one_pulse: assert property (CONVERTER_TRIGGER |=> !CONVERTER_TRIGGER)
        else $error("trigger longer than one cycle");
    a_trig_at_off: assert property (CONVERTER_TRIGGER |-> $fell(CURRENT_SOURCE_ON))
        else $error("trigger without source shut-off");
    a_off_when_disabled: assert property (!$past(ctrl_ff[BIT_UNIT_EN]) |-> !CURRENT_SOURCE_ON)
        else $error("source on while unit disabled");
    a_irq_after_off: assert property (CONVERTER_TRIGGER && irq_en_ff |=> IRQ)
        else $error("interrupt missing after shut-off");
endmodule

/* File: bench/ctu_far_side.sv */
// Far-side model: four level edge sources and a converter start counter
`timescale 1ns/100ps
module ctu_far_side
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] lvl,
    input  wire logic       trig,
    output logic            pin_one,
    output logic            pin_two,
    output logic            tmr_one,
    output logic            tmr_two,
    output int              conv_cnt
);
    // Index equals the select code, so lvl[sel] is the chosen source
    assign {pin_one, pin_two, tmr_one, tmr_two} = lvl;
    // Each trigger pulse starts one conversion
    always_ff @(posedge clk or posedge rst)
        if (rst)
            conv_cnt <= 0;
        else if (trig)
            conv_cnt <= conv_cnt + 1;
endmodule

/* File: bench/charge_time_edge_control_bench.sv */
// Testbench: scenarios for the charge time unit control
`timescale 1ns/100ps
module charge_time_edge_control_bench;
    import ctu_pkg::*;
    logic       mclk = 0, sys_rst = 1, wr = 0, rd = 0, idle = 0;
    logic [3:0] addr = 0, lvl = 0;
    logic [7:0] wdata = 0, rdata;
    logic       pin1, pin2, tt1, tt2, cso, gnd, dgen, ctrig, irq;
    int         conv, mismatches = 0, total_checks = 0;
    always #2.5 mclk = ~mclk;
    ctu_edge_ctrl dut (.MCLK(mclk), .SYS_RST(sys_rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .EDGE_PIN_ONE(pin1), .EDGE_PIN_TWO(pin2), .TIMER_TRIG_ONE(tt1),
        .TIMER_TRIG_TWO(tt2), .IDLE_MODE(idle), .CURRENT_SOURCE_ON(cso), .SOURCE_GROUND(gnd),
        .DELAY_GEN_ON(dgen), .CONVERTER_TRIGGER(ctrig), .IRQ(irq));
    ctu_far_side far (.clk(mclk), .rst(sys_rst), .lvl(lvl), .trig(ctrig), .pin_one(pin1), .pin_two(pin2),
        .tmr_one(tt1), .tmr_two(tt2), .conv_cnt(conv));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Bus cycles; a write leaves one idle cycle so strobes never collide
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        rd <= 1'b1; addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        check(rdata, exp);
    endtask
    // Bounded wait for a level or a one-cycle pulse
    task automatic await(ref logic s);
        int n = 0;
        while (s !== 1'b1 && n < 12)
        begin
            @(negedge mclk);
            n++;
        end
        check(s, 1'b1);
    endtask
    // Sources idle low; pins need several cycles to settle through the filter
    task automatic clean();
        @(posedge mclk) lvl <= 4'h0;
        cyc(6);
        wreg(OFS_CTRL_HIGH, 8'h00);
        wreg(OFS_CTRL_LOW, 8'h00);
        wreg(OFS_IRQ_CLR, 8'h01);
    endtask
    task automatic t_regs();
        rreg(OFS_CTRL_HIGH, RST_CTRL_HIGH);
        wreg(OFS_CTRL_HIGH, 8'h52);
        rreg(OFS_CTRL_HIGH, 8'h12);
        check({gnd, dgen}, 2'b10);
        wreg(OFS_CTRL_HIGH, 8'h90);
        cyc(2);
        check({gnd, dgen}, 2'b01);
        rreg(4'h9, 8'h00);
        clean();
    endtask
    // Full measurement: first edge starts the source, second stops it
    task automatic t_measure(input logic [1:0] s1, input logic [1:0] s2, input logic ie);
        int c0 = conv;
        wreg(OFS_CTRL_LOW, {1'b1, s2, 1'b1, s1, 2'b00});
        wreg(OFS_IRQ_EN, {7'h0, ie});
        wreg(OFS_CTRL_HIGH, 8'h89);
        @(posedge mclk) lvl[s1] <= 1'b1;
        await(cso);
        @(posedge mclk) lvl[s2] <= 1'b1;
        await(ctrig);
        cyc(1);
        check(irq, ie);
        check(8'(conv), 8'(c0 + 1));
        rreg(OFS_IRQ_STAT, 8'h01);
        wreg(OFS_IRQ_CLR, 8'h01);
        rreg(OFS_IRQ_STAT, 8'h00);
        clean();
    endtask
    task automatic t_order();
        wreg(OFS_CTRL_LOW, 8'h94);
        wreg(OFS_CTRL_HIGH, 8'h8d);
        @(posedge mclk) lvl[0] <= 1'b1;
        cyc(6);
        rreg(OFS_CTRL_LOW, 8'h94);
        @(posedge mclk) lvl[1] <= 1'b1;
        await(ctrig);
        clean();
    endtask
    // Gate closed blocks a matching low level; opening it sets status at once
    task automatic t_gate();
        wreg(OFS_CTRL_LOW, 8'h84);
        wreg(OFS_CTRL_HIGH, 8'h81);
        cyc(6);
        check(cso, 1'b0);
        wreg(OFS_CTRL_HIGH, 8'h89);
        await(cso);
        clean();
    endtask
    task automatic t_idle();
        wreg(OFS_CTRL_LOW, 8'h94);
        wreg(OFS_CTRL_HIGH, 8'h08);
        @(posedge mclk) lvl[1] <= 1'b1;
        cyc(6);
        rreg(OFS_CTRL_LOW, 8'h94);
        @(posedge mclk) idle <= 1'b1;
        wreg(OFS_CTRL_HIGH, 8'ha8);
        cyc(6);
        rreg(OFS_CTRL_LOW, 8'h94);
        @(posedge mclk) idle <= 1'b0;
        await(cso);
        clean();
    endtask
    task automatic t_soft();
        wreg(OFS_CTRL_LOW, 8'h01);
        wreg(OFS_CTRL_HIGH, 8'h81);
        cyc(2);
        check(cso, 1'b1);
        rreg(OFS_UNIT_STAT, 8'h06);
        wreg(OFS_CTRL_LOW, 8'h03);
        await(ctrig);
        clean();
    endtask
    initial
    begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs();
        for (int s = 0; s < 4; s++)
            t_measure(2'(s), 2'(s + 1), s[0]);
        t_order();
        t_gate();
        t_idle();
        t_soft();
        tally_and_finish();
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        #20000;
        mismatches++;
        tally_and_finish();
    end
endmodule
bind ctu_edge_ctrl ctu_edge_ctrl_asserts u_chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EDGE_PIN_ONE(EDGE_PIN_ONE),
    .EDGE_PIN_TWO(EDGE_PIN_TWO), .TIMER_TRIG_ONE(TIMER_TRIG_ONE), .TIMER_TRIG_TWO(TIMER_TRIG_TWO),
    .IDLE_MODE(IDLE_MODE), .CURRENT_SOURCE_ON(CURRENT_SOURCE_ON), .SOURCE_GROUND(SOURCE_GROUND),
    .DELAY_GEN_ON(DELAY_GEN_ON), .CONVERTER_TRIGGER(CONVERTER_TRIGGER), .IRQ(IRQ));
